// [pkg/cac_defines.vh]
// Constants for the configuration, access and counter block
`ifndef CAC_DEFINES_VH
`define CAC_DEFINES_VH

// Configuration page addresses
`define CAC_PG_CFG0        8'h29
`define CAC_PG_CFG1        8'h2a
`define CAC_PG_KEYLOCK     8'h2d
`define CAC_PG_KEY0_LO     8'h30
`define CAC_PG_KEY0_HI     8'h33
`define CAC_PG_KEY1_LO     8'h34
`define CAC_PG_KEY1_HI     8'h37
`define CAC_PG_CFG_LO      8'h29
`define CAC_PG_CFG_HI      8'h3b

// Field positions, page 29h
`define CAC_B_RID          0
`define CAC_B_SECMSG       1
`define CAC_B_RDOPEN       2
`define CAC_B_INCOPEN      3
`define CAC_B_USRFRZ       6
`define CAC_B_PROTECT_READ_TOO         7
// Field positions, key lock byte
`define CAC_B_KFRZ         5
`define CAC_B_K0LK         6
`define CAC_B_K1LK         7

// Reset values and limits
`define CAC_RST_PSP        8'h3c
`define CAC_LAST_PAGE      8'h3b
`define CAC_RST_VCT        8'h05
`define CAC_RST_AFL        10'h000
`define CAC_RST_CTR        24'h000000
`define CAC_CTR_MAX        24'h0fffff

// Access states
`define CAC_ST_IDLE        2'h0
`define CAC_ST_ACTIVE      2'h1
`define CAC_ST_REVEALED    2'h2
`define CAC_ST_KEYED       2'h3

// Command codes
`define CAC_CMD_READ       3'h0
`define CAC_CMD_WRITE      3'h1
`define CAC_CMD_CTR_RD     3'h2
`define CAC_CMD_CTR_INC    3'h3
`define CAC_CMD_VIRTUAL_CARD_SELECT_LAST_CMD       3'h4
`define CAC_CMD_AUTH_FAIL  3'h5
`define CAC_CMD_AUTH       3'h6

`endif

// [design/cac_counter.v]
// One 24-bit one-way counter with overflow refusal
`timescale 1ns/1ps
`include "cac_defines.vh"

module cac_counter #(
   parameter W = 24
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         arst_n,
   // Increment request
   input  wire         inc_req,
   input  wire [W-1:0] inc_val,
   // Result
   output reg          inc_nak,
   output reg  [W-1:0] value_r
);

   wire [W:0] sum = {1'b0, value_r} + {1'b0, inc_val};
   wire       over = (sum > {1'b0, `CAC_CTR_MAX});

   // Refusal decided in the cycle of the request, for the same-edge answer
   always @* begin
      inc_nak = 1'b0;
      if (inc_req && (inc_val != {W{1'b0}}) && over) begin
         inc_nak = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         value_r <= `CAC_RST_CTR;
      end else if (inc_req && !inc_nak) begin
         value_r <= sum[W-1:0];
      end
   end

endmodule // cac_counter

// [design/cac_config_access.v]
// Configuration, access control and counters of the ticket IC
`timescale 1ns/1ps
`include "cac_defines.vh"

module cac_config_access #(
   parameter CTR_W = 24,
   parameter AFL_W = 10
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             arst_n,
   // Session state from the protocol engine
   input  wire [1:0]       sess_state,
   input  wire             power_up,
   // Command strobe and fields
   input  wire             cmd_valid,
   input  wire [2:0]       cmd_code,
   input  wire [7:0]       cmd_page,
   input  wire [31:0]      cmd_data,
   input  wire [1:0]       cmd_ctr_sel,
   // Response
   output reg              rsp_valid,
   output reg              rsp_ack,
   output reg              rsp_nak,
   output reg  [31:0]      rsp_data,
   // Configuration outputs
   output reg              random_id_enable,
   output reg              secure_msg_enable,
   output reg  [7:0]       active_protect_read_too_page,
   output reg              active_read_too,
   output reg              auth_blocked
);

   // ==========================================================
   // Stored configuration
   // ==========================================================
   reg              rid_r;
   reg              secmsg_r;
   reg [7:0]        psp_r;
   reg              protect_read_too_r;
   reg              rdopen_r;
   reg              incopen_r;
   reg              usrfrz_r;
   reg [7:0]        vct_r;
   reg [AFL_W-1:0]  afl_r;
   reg              k0lk_r;
   reg              k1lk_r;
   reg              kfrz_r;
   reg [AFL_W-1:0]  fail_cnt_r;

   // Counter wiring
   reg  [2:0]       inc_req;
   reg  [CTR_W-1:0] inc_val_r;
   wire [2:0]       inc_nak;
   wire [CTR_W-1:0] ctr_val [0:2];

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ctr
         cac_counter #(
            .W       (CTR_W)
         ) u_ctr (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .inc_req (inc_req[gi]),
            .inc_val (inc_val_r),
            .inc_nak (inc_nak[gi]),
            .value_r (ctr_val[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Access decode
   // ==========================================================
   wire keyed     = (sess_state == `CAC_ST_KEYED);
   wire open_st   = (sess_state == `CAC_ST_ACTIVE) ||
                    (sess_state == `CAC_ST_REVEALED);
   wire protect_read_too_on   = (active_protect_read_too_page <= `CAC_LAST_PAGE);
   wire pg_protect_read_too   = protect_read_too_on && (cmd_page >= active_protect_read_too_page);
   wire rd_block  = pg_protect_read_too && active_read_too && open_st;
   wire wr_block  = pg_protect_read_too && !keyed;
   wire is_cfg    = (cmd_page >= `CAC_PG_CFG_LO) &&
                    (cmd_page <= `CAC_PG_CFG_HI);
   wire is_key0   = (cmd_page >= `CAC_PG_KEY0_LO) &&
                    (cmd_page <= `CAC_PG_KEY0_HI);
   wire is_key1   = (cmd_page >= `CAC_PG_KEY1_LO) &&
                    (cmd_page <= `CAC_PG_KEY1_HI);
   wire is_klock  = (cmd_page == `CAC_PG_KEYLOCK);
   // Lock checks on configuration items
   wire cfg_lock  = usrfrz_r && (cmd_page == `CAC_PG_CFG0 ||
                    cmd_page == `CAC_PG_CFG1);
   wire key_lock  = (is_key0 && k0lk_r) ||
                    (is_key1 && k1lk_r);
   wire kl_lock   = is_klock && kfrz_r;
   wire cfg_nak   = is_cfg && (cfg_lock || key_lock || kl_lock);
   wire ctr_ok_rd = keyed || (open_st &&
                    (cmd_ctr_sel != 2'd2 || rdopen_r));
   wire ctr_ok_in = keyed || (open_st &&
                    (cmd_ctr_sel != 2'd2 || incopen_r));
   wire ctr_sel_ok = (cmd_ctr_sel != 2'd3);
   wire lim_hit   = (afl_r != {AFL_W{1'b0}}) &&
                    (fail_cnt_r >= afl_r);

   // Pending counter answer
   reg        inc_pend_r;
   reg [1:0]  inc_sel_r;

   // ==========================================================
   // Command processing
   // ==========================================================
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rid_r             <= 1'b0;
         secmsg_r          <= 1'b0;
         psp_r             <= `CAC_RST_PSP;
         protect_read_too_r            <= 1'b1;
         rdopen_r          <= 1'b1;
         incopen_r         <= 1'b1;
         usrfrz_r          <= 1'b0;
         vct_r             <= `CAC_RST_VCT;
         afl_r             <= `CAC_RST_AFL;
         k0lk_r            <= 1'b0;
         k1lk_r            <= 1'b0;
         kfrz_r            <= 1'b0;
         fail_cnt_r        <= {AFL_W{1'b0}};
         rsp_valid         <= 1'b0;
         rsp_ack           <= 1'b0;
         rsp_nak           <= 1'b0;
         rsp_data          <= 32'h00000000;
         random_id_enable  <= 1'b0;
         secure_msg_enable <= 1'b0;
         active_protect_read_too_page  <= `CAC_RST_PSP;
         active_read_too   <= 1'b1;
         auth_blocked      <= 1'b0;
         inc_req           <= 3'b000;
         inc_pend_r        <= 1'b0;
         inc_sel_r         <= 2'd0;
         inc_val_r         <= {CTR_W{1'b0}};
      end else begin
         rsp_valid         <= 1'b0;
         rsp_ack           <= 1'b0;
         rsp_nak           <= 1'b0;
         inc_req           <= 3'b000;
         inc_pend_r        <= 1'b0;
         secure_msg_enable <= secmsg_r;
         auth_blocked      <= lim_hit;
         if (power_up) begin
            random_id_enable <= rid_r;
            active_protect_read_too_page <= psp_r;
            active_read_too  <= protect_read_too_r;
         end
         // Counter answer one cycle after the increment
         if (inc_pend_r) begin
            rsp_valid <= 1'b1;
            rsp_ack   <= !inc_nak[inc_sel_r];
            rsp_nak   <= inc_nak[inc_sel_r];
         end
         if (cmd_valid) begin
            case (cmd_code)
               `CAC_CMD_READ: begin
                  rsp_valid <= 1'b1;
                  if (rd_block) begin
                     rsp_nak <= 1'b1;
                  end else begin
                     rsp_ack  <= 1'b1;
                     rsp_data <= 32'h00000000;
                     if (cmd_page == `CAC_PG_CFG0) begin
                        rsp_data <= {psp_r, vct_r,
                           protect_read_too_r, usrfrz_r, 2'b00, incopen_r,
                           rdopen_r, 2'b00,
                           6'h00, secmsg_r, rid_r};
                     end else if (cmd_page == `CAC_PG_CFG1) begin
                        rsp_data <= {16'h0000, 6'h00,
                           afl_r[9:8], afl_r[7:0]};
                     end else if (is_klock) begin
                        rsp_data <= {24'h000000, k1lk_r, k0lk_r,
                           kfrz_r, 5'h00};
                     end
                     // Counters never appear in page reads
                  end
               end
               `CAC_CMD_WRITE: begin
                  rsp_valid <= 1'b1;
                  if (cfg_nak || wr_block) begin
                     rsp_nak <= 1'b1;
                  end else begin
                     rsp_ack <= 1'b1;
                     if (cmd_page == `CAC_PG_CFG0) begin
                        rid_r     <= cmd_data[`CAC_B_RID];
                        secmsg_r  <= cmd_data[`CAC_B_SECMSG];
                        rdopen_r  <= cmd_data[8+`CAC_B_RDOPEN];
                        incopen_r <= cmd_data[8+`CAC_B_INCOPEN];
                        usrfrz_r  <= cmd_data[8+`CAC_B_USRFRZ];
                        protect_read_too_r    <= cmd_data[8+`CAC_B_PROTECT_READ_TOO];
                        vct_r     <= cmd_data[23:16];
                        psp_r     <= cmd_data[31:24];
                     end else if (cmd_page == `CAC_PG_CFG1) begin
                        afl_r <= cmd_data[AFL_W-1:0];
                     end else if (is_klock) begin
                        kfrz_r <= kfrz_r | cmd_data[`CAC_B_KFRZ];
                        k0lk_r <= k0lk_r | cmd_data[`CAC_B_K0LK];
                        k1lk_r <= k1lk_r | cmd_data[`CAC_B_K1LK];
                     end
                  end
               end
               `CAC_CMD_CTR_RD: begin
                  rsp_valid <= 1'b1;
                  if (ctr_ok_rd && ctr_sel_ok) begin
                     rsp_ack  <= 1'b1;
                     rsp_data <= {{(32-CTR_W){1'b0}},
                                  ctr_val[cmd_ctr_sel]};
                  end else begin
                     rsp_nak <= 1'b1;
                  end
               end
               `CAC_CMD_CTR_INC: begin
                  if (ctr_ok_in && ctr_sel_ok) begin
                     inc_req[cmd_ctr_sel] <= 1'b1;
                     inc_pend_r <= 1'b1;
                     inc_sel_r  <= cmd_ctr_sel;
                     // Operand held, the bus is free after the take
                     inc_val_r  <= cmd_data[CTR_W-1:0];
                  end else begin
                     rsp_valid <= 1'b1;
                     rsp_nak   <= 1'b1;
                  end
               end
               `CAC_CMD_VIRTUAL_CARD_SELECT_LAST_CMD: begin
                  rsp_valid <= 1'b1;
                  rsp_ack   <= 1'b1;
                  rsp_data  <= {24'h000000, vct_r};
               end
               `CAC_CMD_AUTH_FAIL: begin
                  if (afl_r != {AFL_W{1'b0}} && !lim_hit) begin
                     fail_cnt_r <= fail_cnt_r +
                                   {{(AFL_W-1){1'b0}}, 1'b1};
                  end
               end
               `CAC_CMD_AUTH: begin
                  rsp_valid <= 1'b1;
                  rsp_ack   <= !lim_hit;
                  rsp_nak   <= lim_hit;
               end
               default: begin
                  rsp_valid <= 1'b1;
                  rsp_nak   <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // cac_config_access

// [testbench/cac_config_access_chk.sv]
// Port assertions for the configuration and counter block
`timescale 1ns/1ps
`include "cac_defines.vh"

module cac_config_access_chk (
   // Clock and reset
   input logic        clk_sys,
   input logic        arst_n,
   // Requests
   input logic [1:0]  sess_state,
   input logic        power_up,
   input logic        cmd_valid,
   input logic [2:0]  cmd_code,
   input logic [7:0]  cmd_page,
   input logic [31:0] cmd_data,
   input logic [1:0]  cmd_ctr_sel,
   // Answers and settings
   input logic        rsp_valid,
   input logic        rsp_ack,
   input logic        rsp_nak,
   input logic        random_id_enable,
   input logic [7:0]  active_protect_read_too_page,
   input logic        active_read_too,
   input logic        auth_blocked
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // ==========
   // Helpers
   wire hit = cmd_page >= active_protect_read_too_page &&
              active_protect_read_too_page <= `CAC_LAST_PAGE;
   wire inc = cmd_valid && cmd_code == `CAC_CMD_CTR_INC;
   wire ctr = cmd_code == `CAC_CMD_CTR_RD || inc;
   wire opn = sess_state == `CAC_ST_ACTIVE || sess_state == `CAC_ST_REVEALED;
   // ==========
   // Assertions
   a_answer_next: assert property (cmd_valid && !inc &&
      cmd_code != `CAC_CMD_AUTH_FAIL |=> rsp_valid) else $error("No answer");
   a_incr_bound: assert property (inc |-> ##[1:2] rsp_valid)
      else $error("Increment unanswered");
   a_resp_kind: assert property (rsp_valid ? rsp_ack != rsp_nak :
      !(rsp_ack || rsp_nak)) else $error("Bad answer kind");
   a_cfg_hold: assert property (!power_up |=>
      $stable({random_id_enable, active_protect_read_too_page, active_read_too}))
      else $error("Setting moved without power up");
   a_zero_incr: assert property (inc && cmd_data[23:0] == 24'h0 &&
      cmd_ctr_sel < 2'h2 && sess_state != `CAC_ST_IDLE |-> ##2 rsp_ack)
      else $error("Zero increment");
   a_sel_refuse: assert property (cmd_valid && ctr &&
      cmd_ctr_sel == 2'h3 |=> rsp_nak) else $error("Bad counter taken");
   a_protect_read_too_write: assert property (cmd_valid && hit &&
      cmd_code == `CAC_CMD_WRITE && sess_state != `CAC_ST_KEYED |=> rsp_nak)
      else $error("Protected write taken");
   a_protect_read_too_read: assert property (cmd_valid && hit && opn &&
      cmd_code == `CAC_CMD_READ && active_read_too |=> rsp_nak)
      else $error("Protected read taken");
   a_auth_refuse: assert property (cmd_valid && auth_blocked &&
      cmd_code == `CAC_CMD_AUTH |=> rsp_nak) else $error("Auth not refused");
   a_block_stay: assert property (auth_blocked |=> auth_blocked)
      else $error("Block released");
   c_power: cover property (power_up);
   c_nak: cover property (rsp_nak);
   c_block: cover property ($rose(auth_blocked));
endmodule // cac_config_access_chk

// [testbench/cac_reader_model.sv]
// Reader model issuing commands to the configuration block
`timescale 1ns/1ps

module cac_reader_model (
   // Clock
   input  logic        clk_sys,
   // Command
   output logic        cmd_valid,
   output logic [2:0]  cmd_code,
   output logic [7:0]  cmd_page,
   output logic [31:0] cmd_data,
   output logic [1:0]  cmd_ctr_sel,
   // Answer
   input  logic        rsp_valid,
   input  logic        rsp_ack,
   input  logic        rsp_nak,
   input  logic [31:0] rsp_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      cmd_page = 8'h00;
      cmd_data = 32'h0;
      cmd_ctr_sel = 2'h0;
   end
   // ==========
   // One command after gap idle cycles
   task automatic issue(input logic [2:0] c, input logic [7:0] p,
      input logic [31:0] d, input logic [1:0] s, input int gap,
      output logic got, output logic ack, output logic nak,
      output logic [31:0] q);
      got = 1'b0;
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_page <= p;
      cmd_data <= d;
      cmd_ctr_sel <= s;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      // Released fields show inverted values
      cmd_code <= ~c;
      cmd_page <= ~p;
      cmd_data <= ~d;
      cmd_ctr_sel <= ~s;
      for (int i = 0; i < 3 && !got; i++) begin
         #1;
         got = rsp_valid === 1'b1;
         ack = rsp_ack;
         nak = rsp_nak;
         q = rsp_data;
         if (!got) @(posedge clk_sys);
      end
   endtask
endmodule // cac_reader_model

// [testbench/test_config_access_counters.sv]
// Self-checking bench for the configuration and counter block
`timescale 1ns/1ps
`include "cac_defines.vh"

module test_config_access_counters;
   logic        clk_sys, arst_n, power_up, cmd_valid, rsp_valid;
   logic [1:0]  sess_state, cmd_ctr_sel;
   logic [2:0]  cmd_code;
   logic [7:0]  cmd_page, active_protect_read_too_page;
   logic [31:0] cmd_data, rsp_data, seed, rd;
   logic        rsp_ack, rsp_nak, random_id_enable, secure_msg_enable;
   logic        active_read_too, auth_blocked, got, ack, nak;
   int          bad_count, samples_checked, ctr_m[3];
   cac_config_access DUT (.*);
   cac_reader_model rdr (.*);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ==========
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic [2:0] c, input logic [7:0] p,
      input logic [31:0] d, input logic [1:0] s, input logic ok);
      rdr.issue(c, p, d, s, rnd() % 3, got, ack, nak, rd);
      check({got, ack, nak}, {1'b1, ok, !ok});
   endtask
   task automatic wr(input logic [7:0] p, input logic [31:0] d, input ok);
      op(`CAC_CMD_WRITE, p, d, 2'h0, ok);
   endtask
   task automatic incr(input int s, input logic [23:0] d);
      logic ok;
      ok = ctr_m[s] + d <= `CAC_CTR_MAX;
      op(`CAC_CMD_CTR_INC, 8'h00, {8'h00, d}, s[1:0], ok);
      if (ok) ctr_m[s] += d;
      op(`CAC_CMD_CTR_RD, 8'h00, 32'h0, s[1:0], 1'b1);
      check(rd[23:0], ctr_m[s][23:0]);
   endtask
   task automatic go(input logic [1:0] s);
      @(posedge clk_sys);
      sess_state <= s;
   endtask
   task automatic pwr;
      go(`CAC_ST_IDLE);
      @(posedge clk_sys);
      power_up <= 1'b1;
      @(posedge clk_sys);
      power_up <= 1'b0;
      #1;
   endtask
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      complete_run;
   end
   // ==========
   // Main sequence
   initial begin
      seed = 32'h0757;
      {arst_n, power_up, sess_state, bad_count, samples_checked} = '0;
      ctr_m = '{0, 0, 0};
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      go(`CAC_ST_ACTIVE);
      #1;
      check({random_id_enable, secure_msg_enable, active_protect_read_too_page,
         active_read_too, auth_blocked}, {2'b00, `CAC_RST_PSP, 2'b10});
      op(`CAC_CMD_READ, `CAC_PG_CFG0, 32'h0, 2'h0, 1'b1);
      check(rd, 32'h3c058c00);
      op(`CAC_CMD_VIRTUAL_CARD_SELECT_LAST_CMD, 8'h00, 32'h0, 2'h0, 1'b1);
      check(rd[7:0], `CAC_RST_VCT);
      $display("Defaults done");
      for (int k = 0; k < 9; k++)
         incr(k % 3, rnd() & 24'h03ffff);
      incr(1, `CAC_CTR_MAX - ctr_m[1][23:0]);
      incr(1, 24'h1);
      incr(1, 24'h0);
      op(`CAC_CMD_CTR_RD, 8'h00, 32'h0, 2'h3, 1'b0);
      op(3'h7, 8'h00, 32'h0, 2'h0, 1'b0);
      $display("Counters done");
      go(`CAC_ST_KEYED);
      wr(`CAC_PG_CFG0, 32'h10a58003, 1'b1);
      @(posedge clk_sys);
      #1;
      check({random_id_enable, secure_msg_enable, active_protect_read_too_page},
         {2'b01, `CAC_RST_PSP});
      op(`CAC_CMD_VIRTUAL_CARD_SELECT_LAST_CMD, 8'h00, 32'h0, 2'h0, 1'b1);
      check(rd[7:0], 8'ha5);
      pwr;
      check({random_id_enable, active_protect_read_too_page, active_read_too},
         {1'b1, 8'h10, 1'b1});
      go(`CAC_ST_REVEALED);
      wr(8'h10, rnd(), 1'b0);
      wr(8'h0f, rnd(), 1'b1);
      op(`CAC_CMD_READ, 8'h3b, 32'h0, 2'h0, 1'b0);
      op(`CAC_CMD_CTR_INC, 8'h00, 32'h1, 2'h2, 1'b0);
      op(`CAC_CMD_CTR_RD, 8'h00, 32'h0, 2'h2, 1'b0);
      go(`CAC_ST_KEYED);
      op(`CAC_CMD_READ, 8'h3b, 32'h0, 2'h0, 1'b1);
      incr(2, 24'h5);
      wr(`CAC_PG_CFG0, 32'h10a50003, 1'b1);
      pwr;
      check(active_read_too, 1'b0);
      go(`CAC_ST_REVEALED);
      op(`CAC_CMD_READ, 8'h3b, 32'h0, 2'h0, 1'b1);
      wr(8'h3b, 32'h0, 1'b0);
      go(`CAC_ST_KEYED);
      $display("Protection done");
      wr(`CAC_PG_CFG1, 32'h2, 1'b1);
      repeat (2) begin
         op(`CAC_CMD_AUTH, 8'h00, 32'h0, 2'h0, 1'b1);
         rdr.issue(`CAC_CMD_AUTH_FAIL, 8'h0, 32'h0, 2'h0, 0, got, ack, nak, rd);
         check(got, 1'b0);
      end
      op(`CAC_CMD_AUTH, 8'h00, 32'h0, 2'h0, 1'b0);
      check(auth_blocked, 1'b1);
      wr(`CAC_PG_KEYLOCK, 32'h40, 1'b1);
      wr(`CAC_PG_KEY0_LO, rnd(), 1'b0);
      wr(`CAC_PG_KEY0_HI, rnd(), 1'b0);
      wr(`CAC_PG_KEY1_HI, rnd(), 1'b1);
      wr(`CAC_PG_KEYLOCK, 32'h20, 1'b1);
      wr(`CAC_PG_KEYLOCK, 32'h80, 1'b0);
      op(`CAC_CMD_READ, `CAC_PG_KEYLOCK, 32'h0, 2'h0, 1'b1);
      check(rd[7:5], 3'b011);
      wr(`CAC_PG_CFG0, 32'h10a5c003, 1'b1);
      wr(`CAC_PG_CFG0, 32'h0, 1'b0);
      wr(`CAC_PG_CFG1, 32'h0, 1'b0);
      $display("Locks done");
      complete_run;
   end
endmodule // test_config_access_counters

bind cac_config_access cac_config_access_chk chk (.*);
